// File: core/idr_reader.sv
// Read-only ID tag byte reader: access control, output pulses and indicators
//
// Contract
// - Address is left hex switch as upper digit, right switch as lower digit.
// - Access mode and output time are taken at power-up only.
// - Auto mode reads as soon as a carrier enters, no trigger needed.
// - Auto mode reads a carrier that stays present only once until suppress is released.
// - Auto mode re-arms when carrier leaves or suppress is released.
// - Sync mode idles until trigger, then tries one read at once.
// - Sync trigger without carrier flags code bit 2 and pulses failure.
// - Any error forces all eight data outputs to zero.
// - Success and failure outputs last the selected output time.
// - Hold setting keeps result until suppress (auto) or trigger (sync).
// - Success rises 3 ms after the byte appears on the data outputs.
// - Data outputs hold until next access, an error or suppress.
// - Suppress forces the data outputs to zero.
// - Auto mode failed read pulses failure and clears the data.
// - Green indicators mirror the read byte until the next read or an error.
// - Red indicator of the error code bit flashes until the next read.
// - Address beyond the carrier capacity reports code bit 3.
// - A carrier exchange that ends badly reports code bit 0.
// - Unstable host inputs report code bit 6.
// - Switch between positions or internal fault reports code bit 7.
`timescale 1ns/1ps
`include "idr_regs.svh"
module idr_reader #(
  parameter logic [31:0] SETTLE_CYC = `IDR_SETTLE_NS / `IDR_CLK_NS,
  parameter logic [31:0] T0_CYC     = `IDR_T0_MS * (`IDR_MS_NS / `IDR_CLK_NS),
  parameter logic [31:0] T1_CYC     = `IDR_T1_MS * (`IDR_MS_NS / `IDR_CLK_NS),
  parameter logic [31:0] T2_CYC     = `IDR_T2_MS * (`IDR_MS_NS / `IDR_CLK_NS)
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [3:0]        addr_hi_sw,
  input  wire logic [3:0]        addr_lo_sw,
  input  wire idr_pkg::idr_mode_e mode_sw,
  input  wire idr_pkg::idr_time_e time_sw,
  input  wire logic              sw_between,
  input  wire logic              cpu_fault,
  input  wire logic              trigger_in,
  input  wire logic              suppress_in,
  input  wire logic              carrier_present,
  input  wire logic [7:0]        carrier_last_addr,
  input  wire logic              acc_done,
  input  wire logic              acc_ok,
  input  wire logic [7:0]        acc_data,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  output logic                   acc_req,
  output logic [7:0]             acc_addr,
  output logic [7:0]             read_byte_out,
  output logic                   ok_out,
  output logic                   fail_out,
  output logic [7:0]             led_green,
  output logic [7:0]             led_red
);
  import idr_pkg::*;

  // ****************************************
  // Input conditioning
  // ****************************************
  logic [2:0] raw;
  logic [2:0] filt;
  logic [2:0] glitch;
  assign raw = {carrier_present, suppress_in, trigger_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_in
      idr_in_filter #(.N(`IDR_FILT_CYC)) u_filt (
        .clk     (clk),
        .reset_n (reset_n),
        .din     (raw[gi]),
        .q       (filt[gi]),
        .glitch  (glitch[gi])
      );
    end
  endgenerate

  wire trig_f = filt[0];
  wire sup_f  = filt[1];
  wire car_f  = filt[2];

  logic trig_d_r;
  logic sup_d_r;
  wire  trig_rise = trig_f && !trig_d_r;
  wire  sup_rise  = sup_f && !sup_d_r;
  wire  sup_fall  = !sup_f && sup_d_r;

  // ****************************************
  // Power-up straps
  // ****************************************
  // Straps are taken on the first edge after release, never by the reset itself
  logic      captured_r;
  idr_mode_e mode_r;
  idr_time_e time_r;
  logic      sw_bad_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      captured_r <= 1'b0;
      mode_r     <= MODE_AUTO;
      time_r     <= TIME_0;
      sw_bad_r   <= 1'b0;
    end else if (!captured_r) begin
      captured_r <= 1'b1;
      mode_r     <= mode_sw;
      time_r     <= time_sw;
      sw_bad_r   <= sw_between;
    end
  end

  wire is_auto  = (mode_r == MODE_AUTO);
  wire hold_sel = (time_r == TIME_HOLD);

  // ****************************************
  // Access decisions
  // ****************************************
  idr_state_e st_r;
  idr_state_e st_nxt;
  logic       armed_r;
  logic       unstable_r;
  logic [7:0] err_r;
  logic [7:0] err_pre;
  logic [7:0] err_code;
  logic [31:0] out_cyc;

  wire [7:0] addr_sel = {addr_hi_sw, addr_lo_sw};
  wire idle = (st_r == ST_IDLE) && captured_r;

  wire start_auto = idle && is_auto && armed_r && car_f && !sup_f;
  wire start_sync = idle && !is_auto && trig_rise;
  wire begin_acc  = start_auto || start_sync;

  always_comb begin
    err_pre = 8'h00;
    err_pre[`IDR_ERR_HW]    = sw_bad_r || cpu_fault;
    err_pre[`IDR_ERR_INPUT] = unstable_r;
    err_pre[`IDR_ERR_ADDR]  = addr_sel > carrier_last_addr;
    err_pre[`IDR_ERR_NOCAR] = !is_auto && !car_f;
  end

  wire pre_fail = begin_acc && (err_pre != 8'h00);
  wire acc_end  = (st_r == ST_ACCESS) && acc_done;
  wire acc_fail = acc_end && !acc_ok;
  wire ev_read  = acc_end && acc_ok;
  wire ev_err   = pre_fail || acc_fail;

  assign err_code = pre_fail ? err_pre : (8'h01 << `IDR_ERR_XMIT);

  logic tmr_done;
  wire  ev_ok   = (st_r == ST_SETTLE) && tmr_done;
  wire  rel_ev  = is_auto ? sup_rise : trig_rise;
  wire  release_out = (st_r == ST_HOLD) && (hold_sel ? rel_ev : tmr_done);

  always_comb begin
    unique case (time_r)
      TIME_0:    out_cyc = T0_CYC;
      TIME_1:    out_cyc = T1_CYC;
      TIME_2:    out_cyc = T2_CYC;
      TIME_HOLD: out_cyc = 32'h0;
    endcase
  end

  // Timer serves both the settle gap and the output pulse
  wire        tmr_load = ev_read || ((ev_ok || ev_err) && !hold_sel);
  wire [31:0] tmr_val  = ev_read ? SETTLE_CYC - 32'h1 : out_cyc - 32'h1;

  idr_down_timer u_tmr (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (tmr_load),
    .value   (tmr_val),
    .done    (tmr_done)
  );

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (ev_err) begin
          st_nxt = ST_HOLD;
        end else if (begin_acc) begin
          st_nxt = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (acc_fail) begin
          st_nxt = ST_HOLD;
        end else if (ev_read) begin
          st_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (tmr_done) begin
          st_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (release_out) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // Register port
  // ****************************************
  logic [23:0] flash_div_r;
  logic [15:0] rd_mux;

  always_comb begin
    unique case (reg_addr)
      `IDR_REG_STATUS: rd_mux = {err_r, read_byte_out};
      `IDR_REG_CFG:    rd_mux = {11'h000, armed_r, st_r, time_r[0], mode_r};
      `IDR_REG_FLASH:  rd_mux = flash_div_r[23:8];
      default:         rd_mux = 16'h0000;
    endcase
  end

  // ****************************************
  // State and outputs
  // ****************************************
  logic [23:0] flash_cnt_r;
  logic        flash_ph_r;
  wire         flash_wrap = (flash_cnt_r >= flash_div_r);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= ST_IDLE;
      trig_d_r   <= 1'b0;
      sup_d_r    <= 1'b0;
      reg_rdata  <= 16'h0000;
      flash_div_r <= `IDR_FLASH_RST;
    end else begin
      st_r      <= st_nxt;
      trig_d_r  <= trig_f;
      sup_d_r   <= sup_f;
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      if (reg_wr && (reg_addr == `IDR_REG_FLASH)) begin
        flash_div_r <= {reg_wdata, 8'hFF};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_r <= 1'b1;
    end else if (start_auto) begin
      armed_r <= 1'b0;
    end else if (!car_f || sup_fall) begin
      armed_r <= 1'b1;
    end
  end

  // New glitch wins over the clear of the one being reported
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unstable_r <= 1'b0;
    end else begin
      unstable_r <= (glitch != 3'b000) || (unstable_r && !begin_acc);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_req  <= 1'b0;
      acc_addr <= 8'h00;
    end else begin
      acc_req  <= begin_acc && !pre_fail;
      acc_addr <= begin_acc ? addr_sel : acc_addr;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_byte_out <= 8'h00;
    end else if (ev_err || sup_f) begin
      read_byte_out <= 8'h00;
    end else if (ev_read) begin
      read_byte_out <= acc_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ok_out   <= 1'b0;
      fail_out <= 1'b0;
    end else begin
      ok_out   <= ev_ok || (ok_out && !release_out);
      fail_out <= ev_err || (fail_out && !release_out);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_r     <= 8'h00;
      led_green <= 8'h00;
    end else if (ev_err) begin
      err_r     <= err_code;
      led_green <= 8'h00;
    end else if (ev_read) begin
      err_r     <= 8'h00;
      led_green <= acc_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_cnt_r <= 24'h000000;
      flash_ph_r  <= 1'b0;
      led_red     <= 8'h00;
    end else begin
      flash_cnt_r <= flash_wrap ? 24'h000000 : flash_cnt_r + 24'h000001;
      flash_ph_r  <= flash_wrap ? !flash_ph_r : flash_ph_r;
      led_red     <= err_r & {8{flash_ph_r}};
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [31:0] since_read_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since_read_r <= 32'h0;
    end else begin
      since_read_r <= ev_read ? 32'h1 : since_read_r + 32'h1;
    end
  end

  property p_addr;
    begin_acc && !pre_fail |=> acc_req && acc_addr == $past(addr_sel);
  endproperty
  a_addr: assert property (p_addr) else $error("address not from switches");

  property p_straps;
    captured_r && $past(captured_r) |-> $stable(mode_r) && $stable(time_r);
  endproperty
  a_straps: assert property (p_straps) else $error("straps changed");

  property p_auto_go;
    start_auto && err_pre == 8'h00 |=> acc_req ##1 st_r == ST_ACCESS;
  endproperty
  a_auto_go: assert property (p_auto_go) else $error("auto read missing");

  property p_no_reread;
    is_auto && !armed_r && car_f |=> !acc_req;
  endproperty
  a_no_reread: assert property (p_no_reread) else $error("carrier read twice");

  property p_nocar;
    start_sync && !car_f |=> fail_out && err_r[`IDR_ERR_NOCAR] && !acc_req;
  endproperty
  a_nocar: assert property (p_nocar) else $error("missing carrier not flagged");

  property p_err_zero;
    ev_err |=> read_byte_out == 8'h00 && fail_out;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("data kept on error");

  property p_settle;
    $rose(ok_out) |-> since_read_r == SETTLE_CYC + 32'h1;
  endproperty
  a_settle: assert property (p_settle) else $error("settle time wrong");

  property p_hold;
    ok_out && hold_sel && is_auto && !sup_rise |=> ok_out;
  endproperty
  a_hold: assert property (p_hold) else $error("held result dropped");

  property p_sup;
    sup_f |=> read_byte_out == 8'h00;
  endproperty
  a_sup: assert property (p_sup) else $error("suppress did not clear");

  property p_xmit;
    acc_fail |=> fail_out && err_r == 8'h01 ##1 fail_out;
  endproperty
  a_xmit: assert property (p_xmit) else $error("transfer error lost");

  property p_green;
    ev_read |=> led_green == $past(acc_data) && err_r == 8'h00;
  endproperty
  a_green: assert property (p_green) else $error("green not mirrored");

  c_read_ok: cover property ($rose(ok_out));
  c_nocar:   cover property (start_sync && !car_f);
  c_rearm:   cover property (is_auto && sup_fall && car_f);
endmodule

// File: core/idr_regs.svh
// Offsets, field positions, reset values and timing figures of the ID tag byte reader
`ifndef IDR_REGS_SVH
`define IDR_REGS_SVH
`define IDR_CLK_NS        5
`define IDR_SETTLE_NS     3000000
`define IDR_T0_MS         10
`define IDR_T1_MS         50
`define IDR_T2_MS         100
`define IDR_MS_NS         1000000
`define IDR_FILT_CYC      4
`define IDR_REG_STATUS    4'h0
`define IDR_REG_CFG       4'h4
`define IDR_REG_FLASH     4'h8
`define IDR_FLASH_RST     24'h2FAF08
`define IDR_ERR_XMIT      0
`define IDR_ERR_NOCAR     2
`define IDR_ERR_ADDR      3
`define IDR_ERR_INPUT     6
`define IDR_ERR_HW        7
`endif

// File: core/idr_pkg.sv
// Types shared by the ID tag byte reader
package idr_pkg;
  typedef enum logic {
    MODE_AUTO = 1'b0,
    MODE_SYNC = 1'b1
  } idr_mode_e;
  typedef enum logic [1:0] {
    TIME_0    = 2'b00,
    TIME_1    = 2'b01,
    TIME_2    = 2'b10,
    TIME_HOLD = 2'b11
  } idr_time_e;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_SETTLE = 2'b10,
    ST_HOLD   = 2'b11
  } idr_state_e;
endpackage

// File: core/idr_in_filter.sv
// Two-flop synchroniser and run-length filter for one host input
`timescale 1ns/1ps
module idr_in_filter #(
  parameter int N = 4
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      q,
  output logic      glitch
);
  logic       s1_r;
  logic       s2_r;
  logic [7:0] cnt_r;

  // Glitch: input moved, then came back before it was accepted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      cnt_r  <= 8'h00;
      q      <= 1'b0;
      glitch <= 1'b0;
    end else begin
      s1_r   <= din;
      s2_r   <= s1_r;
      glitch <= (s2_r == q) && (cnt_r != 8'h00);
      if (s2_r == q) begin
        cnt_r <= 8'h00;
      end else if (cnt_r == 8'(N - 1)) begin
        cnt_r <= 8'h00;
        q     <= s2_r;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule

// File: core/idr_down_timer.sv
// Loadable down counter; done pulses one cycle after the count reaches one
`timescale 1ns/1ps
module idr_down_timer (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic [31:0] value,
  output logic             done
);
  logic [31:0] cnt_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 32'h0;
      done  <= 1'b0;
    end else begin
      done <= !load && (cnt_r == 32'h1);
      if (load) begin
        cnt_r <= value;
      end else if (cnt_r != 32'h0) begin
        cnt_r <= cnt_r - 32'h1;
      end
    end
  end
endmodule

// File: tb/idr_carrier_model.sv
// Behavioural data carrier answering the reader's byte requests
`timescale 1ns/1ps
module idr_carrier_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       acc_req,
  input  wire logic [7:0] acc_addr,
  input  wire logic [3:0] delay,
  input  wire logic       bad,
  output logic            acc_done,
  output logic            acc_ok,
  output logic [7:0]      acc_data
);
  logic       busy_r;
  logic [3:0] cnt_r;
  logic [7:0] addr_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r   <= 1'b0;
      cnt_r    <= 4'h0;
      addr_r   <= 8'h00;
      acc_done <= 1'b0;
      acc_ok   <= 1'b0;
      acc_data <= 8'h00;
    end else begin
      acc_done <= 1'b0;
      acc_ok   <= 1'b0;
      // Idle data lines wander, so a stale byte never passes for an answer
      acc_data <= ~acc_data;
      if (acc_req) begin
        busy_r <= 1'b1;
        cnt_r  <= delay;
        addr_r <= acc_addr;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r   <= 1'b0;
        acc_done <= 1'b1;
        acc_ok   <= !bad;
        acc_data <= addr_r ^ 8'hA5;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

// File: tb/idr_reader_tb.sv
// Self-checking bench for the ID tag byte reader
`timescale 1ns/1ps
module idr_reader_tb;
  import idr_pkg::*;
  localparam logic [31:0] SET = 32'h14;
  localparam logic [31:0] TW  = 32'h1E;
  typedef struct {
    logic [3:0] hi;
    logic [3:0] lo;
    logic [7:0] last;
    logic       bad;
    logic       fault;
    logic [3:0] dly;
    logic [7:0] code;
  } idr_row_s;
  logic        clk, reset_n, sw_between, cpu_fault, trigger_in, suppress_in, present, bad;
  logic        reg_wr, reg_rd, acc_req, acc_done, acc_ok, ok_out, fail_out;
  logic [3:0]  addr_hi_sw, addr_lo_sw, reg_addr, dly;
  logic [7:0]  last_addr, acc_addr, acc_data, read_byte_out, led_green, led_red, red_seen;
  logic [15:0] reg_wdata, reg_rdata, rd;
  idr_mode_e   mode_sw;
  idr_time_e   time_sw;
  int          mismatches, checks, reqs, n, r0;
  idr_row_s    rows[5] = '{
    '{4'h5, 4'hB, 8'hFF, 1'b0, 1'b0, 4'h3, 8'h00},
    '{4'hF, 4'hE, 8'hFD, 1'b0, 1'b0, 4'h3, 8'h08},
    '{4'h0, 4'h0, 8'hFF, 1'b1, 1'b0, 4'hC, 8'h01},
    '{4'hF, 4'hF, 8'hFF, 1'b0, 1'b0, 4'hC, 8'h00},
    '{4'h1, 4'h0, 8'hFF, 1'b0, 1'b1, 4'h3, 8'h80}
  };
  idr_reader #(.SETTLE_CYC(SET), .T0_CYC(TW), .T1_CYC(32'h28), .T2_CYC(32'h32)) i_dut (
    .clk(clk), .reset_n(reset_n), .addr_hi_sw(addr_hi_sw), .addr_lo_sw(addr_lo_sw),
    .mode_sw(mode_sw), .time_sw(time_sw), .sw_between(sw_between), .cpu_fault(cpu_fault),
    .trigger_in(trigger_in), .suppress_in(suppress_in), .carrier_present(present),
    .carrier_last_addr(last_addr), .acc_done(acc_done), .acc_ok(acc_ok),
    .acc_data(acc_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_addr(acc_addr),
    .read_byte_out(read_byte_out), .ok_out(ok_out), .fail_out(fail_out),
    .led_green(led_green), .led_red(led_red));
  idr_carrier_model i_carrier (.clk(clk), .reset_n(reset_n), .acc_req(acc_req),
    .acc_addr(acc_addr), .delay(dly), .bad(bad), .acc_done(acc_done), .acc_ok(acc_ok),
    .acc_data(acc_data));
  // ****************************************
  // Clock, request counter, watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (acc_req === 1'b1) reqs++;
  end
  initial begin
    #100000;
    bad_hit("watchdog expired");
    tally_and_finish();
  end
  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic bad_hit(input string msg);
    mismatches++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) bad_hit($sformatf("%s got %h want %h", msg, got, exp));
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) bad_hit($sformatf("%s got %h want %h", msg, got, exp));
  endtask
  task automatic chk_count(input int got, input int exp, input string msg);
    checks++;
    if (got != exp) bad_hit($sformatf("%s got %0d want %0d", msg, got, exp));
  endtask
  task automatic reg_op(input logic wr, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
  endtask
  task automatic do_reset(input idr_mode_e m, input idr_time_e t);
    @(posedge clk);
    reset_n <= 1'b0;
    mode_sw <= m;
    time_sw <= t;
    repeat (6) @(posedge clk);
    chk_byte(read_byte_out | led_green | {6'h00, ok_out, fail_out}, 8'h00, "reset outputs");
    reset_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  // Counts cycles until the chosen result output reaches lvl; gives up after 400
  task automatic span(input bit okside, input logic lvl, output int k);
    k = 0;
    while ((okside ? ok_out : fail_out) !== lvl && k < 400) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic result(input logic [7:0] code, input logic [7:0] exp, input int tw);
    if (code === 8'h00) begin
      n = 0;
      while (read_byte_out !== exp && n < 400) begin
        @(negedge clk);
        n++;
      end
      span(1'b1, 1'b1, n);
      chk_count(n, SET, "settle before success");
      chk_byte(led_green, exp, "green indicators");
    end else begin
      span(1'b0, 1'b1, n);
      chk_byte(read_byte_out, 8'h00, "data on error");
      chk_byte(led_green, 8'h00, "green on error");
    end
    if (tw > 0) begin
      span(code === 8'h00, 1'b0, n);
      chk_count(n, tw, "output time");
      chk_byte(read_byte_out, code === 8'h00 ? exp : 8'h00, "held data");
    end
    if (code !== 8'h00) begin
      red_seen = 8'h00;
      repeat (600) begin
        @(negedge clk);
        red_seen = red_seen | led_red;
      end
      chk_byte(red_seen, code, "red code");
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {reset_n, sw_between, cpu_fault, trigger_in, suppress_in, bad, reg_wr, reg_rd} = 8'h00;
    {addr_hi_sw, addr_lo_sw, reg_addr, dly} = 16'h0003;
    {last_addr, reg_wdata} = 24'hFF0000;
    mismatches = 0;
    checks = 0;
    reqs = 0;
    present = 1'b1;
    mode_sw = MODE_SYNC;
    time_sw = TIME_0;
    do_reset(MODE_SYNC, TIME_0);
    reg_op(1'b1, 4'h8, 16'h0000);
    reg_op(1'b0, 4'h4, 16'h0000);
    chk_byte({6'h00, rd[1:0]}, 8'h01, "latched straps");
    reg_op(1'b0, 4'hC, 16'h0000);
    chk_word(rd, 16'h0000, "unmapped read");
    foreach (rows[i]) begin
      @(posedge clk);
      {addr_hi_sw, addr_lo_sw, last_addr} <= {rows[i].hi, rows[i].lo, rows[i].last};
      {bad, cpu_fault, dly} <= {rows[i].bad, rows[i].fault, rows[i].dly};
      r0 = reqs;
      @(posedge clk);
      trigger_in <= 1'b1;
      result(rows[i].code, {rows[i].hi, rows[i].lo} ^ 8'hA5, TW);
      chk_count(reqs - r0, (rows[i].code & 8'h88) ? 0 : 1, "accesses per trigger");
      @(posedge clk);
      trigger_in <= 1'b0;
      reg_op(1'b0, 4'h0, 16'h0000);
      chk_word(rd, {rows[i].code, rows[i].code ? 8'h00 : 8'h5B ^ 8'h5B ^ {rows[i].hi,
        rows[i].lo} ^ 8'hA5}, "status word");
      repeat (12) @(posedge clk);
      $display("row %0d done", i);
    end
    // A trigger blip shorter than the filter leaves code bit 6 for the next access
    cpu_fault <= 1'b0;
    trigger_in <= 1'b1;
    repeat (2) @(posedge clk);
    trigger_in <= 1'b0;
    repeat (12) @(posedge clk);
    r0 = reqs;
    trigger_in <= 1'b1;
    result(8'h40, 8'h00, TW);
    chk_count(reqs - r0, 0, "no access on unstable input");
    @(posedge clk);
    trigger_in <= 1'b0;
    $display("unstable input test done");
    present <= 1'b0;
    repeat (12) @(posedge clk);
    trigger_in <= 1'b1;
    result(8'h04, 8'h00, TW);
    @(posedge clk);
    trigger_in <= 1'b0;
    $display("missing carrier test done");
    present <= 1'b0;
    do_reset(MODE_AUTO, TIME_HOLD);
    // Reset brings back the slow flash rate, too slow to see within the red window
    reg_op(1'b1, 4'h8, 16'h0000);
    reg_op(1'b0, 4'h4, 16'h0000);
    chk_byte({6'h00, rd[1:0]}, 8'h02, "auto straps");
    @(posedge clk);
    {addr_hi_sw, addr_lo_sw} <= 8'h3C;
    r0 = reqs;
    @(posedge clk);
    present <= 1'b1;
    result(8'h00, 8'h3C ^ 8'hA5, 0);
    repeat (200) @(negedge clk);
    chk_byte({7'h00, ok_out}, 8'h01, "held success");
    chk_count(reqs - r0, 1, "reads per visit");
    @(posedge clk);
    mode_sw <= MODE_SYNC;
    suppress_in <= 1'b1;
    repeat (10) @(negedge clk);
    chk_byte(read_byte_out, 8'h00, "suppressed data");
    chk_byte({7'h00, ok_out}, 8'h00, "hold released");
    @(posedge clk);
    suppress_in <= 1'b0;
    result(8'h00, 8'h3C ^ 8'hA5, 0);
    chk_count(reqs - r0, 2, "re-armed read");
    @(posedge clk);
    {present, bad, suppress_in} <= 3'h3;
    repeat (10) @(posedge clk);
    suppress_in <= 1'b0;
    repeat (12) @(posedge clk);
    present <= 1'b1;
    result(8'h01, 8'h00, 0);
    $display("self-triggered hold test done");
    tally_and_finish();
  end
endmodule
